// file: src/lock_timer.sv
// Purpose: Sticky lock indicator for the frequency synthesizer
// Assumes: Reference activity arrives already synchronised
// Notes:   Lock is declared after a settle time of steady operation

`timescale 1ns/1ps
`default_nettype none

module lock_timer
  import synth_regs_pkg::*;
#(
  parameter int LOCK_COUNT = LOCK_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic restart,
  input  wire logic ref_ok,
  output logic      locked
);

  logic [15:0] count;
  wire         done = (count == LOCK_COUNT[15:0] - 16'h0001);

  // ----------------------------------------------------------------------
  // Settle counter and sticky flag
  // ----------------------------------------------------------------------
  // A new setting restarts the settle time but a held lock stays sticky
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count  <= 16'h0000;
      locked <= 1'b0;
    end else if (!enable) begin
      count  <= 16'h0000;
      locked <= 1'b0;
    end else if (restart || !ref_ok) begin
      count  <= 16'h0000;
    end else if (!locked) begin
      if (done) locked <= 1'b1;
      count <= count + 16'h0001;
    end
  end

endmodule : lock_timer

`default_nettype wire

// file: src/synth_record_regs.sv
// Purpose: Synthesizer control word and record-path configuration registers
// Assumes: Control-bus front end presents decoded byte reads and writes
// Notes:   Synthesizer word is committed only after a six-byte burst

`timescale 1ns/1ps
`default_nettype none

module synth_record_regs
  import synth_regs_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic        burst_end,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        mclk_active,
  output logic      [15:0] synth_denom,
  output logic      [15:0] synth_numer,
  output logic      [3:0]  synth_int_mult,
  output logic      [1:0]  synth_in_div,
  output logic             synth_frac_mode,
  output logic             synth_enable,
  output logic             synth_locked,
  output logic             synth_cfg_valid,
  output logic      [1:0]  dmic_select,
  output logic             digital_mic_input_one,
  output logic             digital_mic_input_two,
  output logic             analog_front_pd,
  output logic             beep_pass,
  output logic      [2:0]  beep_gain_code,
  output logic signed [7:0] beep_gain_value,
  output logic      [1:0]  mixer_boost,
  output bias_mode_t       adc_bias,
  output bias_mode_t       front_bias
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [7:0]  stage [SYNTH_BYTES];   // Burst staging bytes
  logic [5:0]  stage_seen;            // Bytes written in this burst
  logic [7:0]  mic_beep;
  logic [7:0]  rec_pwr;
  logic [47:0] synth_word;
  logic        ref_meta;
  logic        ref_sync;
  logic        lock_flag;
  logic        commit_pulse;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  wire [15:0] synth_off  = reg_addr - ADDR_SYNTH_B0;
  wire        hit_synth  = (reg_addr >= ADDR_SYNTH_B0) &&
                           (synth_off < 16'(SYNTH_BYTES));
  wire [2:0]  synth_idx  = synth_off[2:0];
  wire        hit_mic    = (reg_addr == ADDR_MIC_BEEP);
  wire        hit_pwr    = (reg_addr == ADDR_REC_PWR);
  wire        wr_synth   = reg_wr && hit_synth;
  // A word is applied only when every byte arrived in one burst
  wire        burst_full = burst_end && (stage_seen == 6'h3f);

  // Multiplier outside 2..8 is refused, keeping the old word
  wire [3:0]  new_mult   = stage[4][6:3];
  wire        mult_ok    = (new_mult >= INT_MULT_MIN) &&
                           (new_mult <= INT_MULT_MAX);

  // ----------------------------------------------------------------------
  // Burst staging
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < SYNTH_BYTES; i++) stage[i] <= 8'h00;
      stage_seen <= 6'h00;
    end else begin
      if (wr_synth) begin
        stage[synth_idx]      <= reg_wdata;
        stage_seen[synth_idx] <= 1'b1;
      end
      if (burst_end) stage_seen <= 6'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Synthesizer word commit
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      synth_word <= {RST_DENOM, RST_NUMER, 1'b0, RST_INT_MULT,
                     RST_IN_DIV, RST_FRAC_MODE, 7'h00, RST_SYNTH_EN};
      commit_pulse <= 1'b0;
    end else begin
      commit_pulse <= 1'b0;
      if (burst_full && mult_ok) begin
        synth_word[47:32] <= {stage[0], stage[1]};
        synth_word[31:16] <= {stage[2], stage[3]};
        synth_word[15]    <= 1'b0;
        synth_word[14:8]  <= stage[4][6:0];
        synth_word[7:1]   <= 7'h00;
        synth_word[0]     <= stage[5][0];
        commit_pulse      <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Record-path registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mic_beep <= RST_MIC_BEEP;
      rec_pwr  <= RST_REC_PWR;
    end else begin
      if (reg_wr && hit_mic) mic_beep <= reg_wdata & MASK_MIC_BEEP;
      if (reg_wr && hit_pwr) rec_pwr  <= reg_wdata & MASK_REC_PWR;
    end
  end

  // ----------------------------------------------------------------------
  // Reference activity synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_meta <= 1'b0;
      ref_sync <= 1'b0;
    end else begin
      ref_meta <= mclk_active;
      ref_sync <= ref_meta;
    end
  end

  lock_timer u_lock (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .enable  (synth_word[POS_SYNTH_EN]),
    .restart (commit_pulse),
    .ref_ok  (ref_sync),
    .locked  (lock_flag)
  );

  // ----------------------------------------------------------------------
  // Read-back; lock bit is live, reserved bits read zero
  // ----------------------------------------------------------------------
  // Byte picker stays in range, so an index past the word gives zero
  function automatic logic [7:0] word_byte(input logic [47:0] w,
                                           input logic [2:0]  i);
    case (i)
      3'h0:    word_byte = w[47:40];
      3'h1:    word_byte = w[39:32];
      3'h2:    word_byte = w[31:24];
      3'h3:    word_byte = w[23:16];
      3'h4:    word_byte = w[15:8];
      3'h5:    word_byte = w[7:0];
      default: word_byte = 8'h00;
    endcase
  endfunction : word_byte

  wire [47:0] synth_rd = {synth_word[47:2], lock_flag,
                          synth_word[0]};
  wire [7:0]  synth_byte = word_byte(synth_rd, synth_idx);
  wire [7:0]  next_rdata = !reg_rd   ? reg_rdata :
                           hit_synth ? synth_byte :
                           hit_mic   ? mic_beep :
                           hit_pwr   ? rec_pwr : 8'h00;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) reg_rdata <= 8'h00;
    else        reg_rdata <= next_rdata;
  end

  // ----------------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------------
  // Fractional output = ref / X * (R + N/M); integer mode ignores N/M
  assign synth_denom     = synth_word[POS_DENOM_HI+7 -: 16];
  assign synth_numer     = synth_word[POS_NUMER_HI+7 -: 16];
  assign synth_int_mult  = synth_word[POS_INT_MULT +: 4];
  assign synth_in_div    = synth_word[POS_IN_DIV +: 2];
  assign synth_frac_mode = synth_word[POS_FRAC_MODE];
  assign synth_enable    = synth_word[POS_SYNTH_EN];
  assign synth_locked    = lock_flag;
  // Zero denominator would divide by zero, so fraction is unusable
  assign synth_cfg_valid = !synth_frac_mode ||
                           (synth_denom != 16'h0000);

  assign dmic_select           = mic_beep[POS_DMIC_SEL +: 2];
  assign digital_mic_input_one = (dmic_select == 2'b01);
  assign digital_mic_input_two = (dmic_select == 2'b10);
  // Reserved code 11 still powers down the front end, the safe side
  assign analog_front_pd       = (dmic_select != 2'b00);
  assign beep_pass             = mic_beep[POS_BEEP_PASS];
  assign beep_gain_code        = mic_beep[POS_BEEP_GAIN +: 3];
  assign beep_gain_value       = beep_gain_db(beep_gain_code);
  assign mixer_boost           = rec_pwr[POS_MIX_BOOST +: 2];
  assign adc_bias   = bias_mode_t'(rec_pwr[POS_ADC_BIAS +: 2]);
  assign front_bias = bias_mode_t'(rec_pwr[POS_FE_BIAS +: 2]);

endmodule : synth_record_regs

`default_nettype wire

// file: src/synth_regs_pkg.sv
// Purpose: Shared constants for the synthesizer and record-path register bank
// Assumes: Byte-wide register access from the control-bus front end
// Notes:   Offsets are 16-bit control-bus register addresses

package synth_regs_pkg;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [15:0] ADDR_SYNTH_B0     = 16'h4002; // Bits 47:40
  localparam logic [15:0] ADDR_MIC_BEEP     = 16'h4008;
  localparam logic [15:0] ADDR_REC_PWR      = 16'h4009;
  localparam int          SYNTH_BYTES       = 6;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] RST_DENOM         = 16'h0753;
  localparam logic [15:0] RST_NUMER         = 16'h0287;
  localparam logic [3:0]  RST_INT_MULT      = 4'h3;
  localparam logic [1:0]  RST_IN_DIV        = 2'h0;
  localparam logic        RST_FRAC_MODE     = 1'b1;
  localparam logic        RST_SYNTH_EN      = 1'b0;
  localparam logic [7:0]  RST_MIC_BEEP      = 8'h00;
  localparam logic [7:0]  RST_REC_PWR       = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------------
  localparam int          POS_DENOM_HI      = 40;
  localparam int          POS_DENOM_LO      = 32;
  localparam int          POS_NUMER_HI      = 24;
  localparam int          POS_NUMER_LO      = 16;
  localparam int          POS_INT_MULT      = 11;
  localparam int          POS_IN_DIV        = 9;
  localparam int          POS_FRAC_MODE     = 8;
  localparam int          POS_LOCK          = 1;
  localparam int          POS_SYNTH_EN      = 0;
  localparam int          POS_DMIC_SEL      = 4;
  localparam int          POS_BEEP_PASS     = 3;
  localparam int          POS_BEEP_GAIN     = 0;
  localparam int          POS_MIX_BOOST     = 5;
  localparam int          POS_ADC_BIAS      = 3;
  localparam int          POS_FE_BIAS       = 1;
  localparam logic [7:0]  MASK_MIC_BEEP     = 8'h3f;
  localparam logic [7:0]  MASK_REC_PWR      = 8'h7e;
  localparam logic [3:0]  INT_MULT_MIN      = 4'h2;
  localparam logic [3:0]  INT_MULT_MAX      = 4'h8;

  // ----------------------------------------------------------------------
  // Lock detection timing
  // ----------------------------------------------------------------------
  localparam int          CLK_MHZ           = 20;
  localparam int          LOCK_TIME_US      = 100;
  localparam int          LOCK_CYCLES       = LOCK_TIME_US * CLK_MHZ;

  // Record-path bias modes
  typedef enum logic [1:0] {
    BIAS_NORMAL, BIAS_EXTREME_SAVE, BIAS_SAVE, BIAS_ENHANCED
  } bias_mode_t;

  // Beep gain in dB for each code
  function automatic logic signed [7:0] beep_gain_db(input logic [2:0] c);
    case (c)
      3'h0:    beep_gain_db = 8'sd0;
      3'h1:    beep_gain_db = 8'sd6;
      3'h2:    beep_gain_db = 8'sd10;
      3'h3:    beep_gain_db = 8'sd14;
      3'h4:    beep_gain_db = -8'sd23;
      3'h5:    beep_gain_db = 8'sd20;
      3'h6:    beep_gain_db = 8'sd26;
      default: beep_gain_db = 8'sd32;
    endcase
  endfunction : beep_gain_db

endpackage : synth_regs_pkg

// file: verif/host_model.sv
// Purpose: Control-bus host that reaches the register bank
// Assumes: Requests launched on the falling edge, one byte per cycle
// Notes:   Released address and data lines show the inverse value
`timescale 1ns/1ps
`default_nettype none
module host_model
  import synth_regs_pkg::*;
(
  input  wire logic        sys_clk,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic             burst_end,
  output logic      [15:0] reg_addr,
  output logic      [7:0]  reg_wdata,
  input  wire logic [7:0]  reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    burst_end = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
  end

  // Drop a strobe and scramble what it qualified
  task automatic idle();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask : idle

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    idle();
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    idle();
    @(negedge sys_clk);
    d = reg_rdata;
  endtask : rd

  // Word goes out back to back, high byte first; n below 6 cuts it short
  task automatic burst(input logic [47:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      reg_wr = 1'b1;
      reg_addr = 16'(ADDR_SYNTH_B0 + i);
      reg_wdata = w[47-8*i -: 8];
    end
    @(negedge sys_clk);
    idle();
    burst_end = 1'b1;
    @(negedge sys_clk);
    burst_end = 1'b0;
    @(negedge sys_clk);
  endtask : burst
endmodule : host_model
`default_nettype wire

// file: verif/synth_regs_checker.sv
// Purpose: Port-level checks for the synthesizer and record registers
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to every synth_record_regs instance
`timescale 1ns/1ps
`default_nettype none
module synth_regs_checker
  import synth_regs_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        reg_wr,
  input wire logic        burst_end,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [15:0] synth_denom,
  input wire logic [15:0] synth_numer,
  input wire logic [3:0]  synth_int_mult,
  input wire logic        synth_enable,
  input wire logic        synth_locked,
  input wire logic [1:0]  dmic_select,
  input wire logic        analog_front_pd,
  input wire logic        beep_pass,
  input wire logic [2:0]  beep_gain_code,
  input wire logic [1:0]  mixer_boost,
  input wire bias_mode_t  adc_bias,
  input wire bias_mode_t  front_bias
);
  // Slack of one cycle allows either reading of the settle count
  localparam int LOCK_MIN = 1999;
  logic [11:0] en_cnt;

  // Cycles of steady enable; saturates so it never wraps
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) en_cnt <= 12'h000;
    else if (!synth_enable) en_cnt <= 12'h000;
    else if (en_cnt != 12'hfff) en_cnt <= en_cnt + 12'h001;
  end

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_front_pd: assert property (analog_front_pd == (dmic_select != 2'h0))
    else $error("front end power state wrong");
  a_mic_write: assert property (reg_wr && reg_addr == ADDR_MIC_BEEP |=>
    {dmic_select, beep_pass, beep_gain_code} == $past(reg_wdata[5:0]))
    else $error("mic and beep fields not written");
  a_pwr_write: assert property (reg_wr && reg_addr == ADDR_REC_PWR |=>
    {mixer_boost, adc_bias, front_bias} == $past(reg_wdata[6:1]))
    else $error("power fields not written");
  a_mult_range: assert property (synth_int_mult inside {[4'h2:4'h8]})
    else $error("multiplier out of range");
  a_word_commit: assert property (!burst_end && !$past(burst_end) |=>
    $stable({synth_denom, synth_numer, synth_int_mult}))
    else $error("word changed outside a burst end");
  a_lock_sticky: assert property ((synth_locked && synth_enable) ##1
    synth_enable |-> synth_locked)
    else $error("lock dropped while enabled");
  a_lock_clear: assert property (!synth_enable [*3] |-> !synth_locked)
    else $error("lock kept while disabled");
  a_lock_late: assert property ($rose(synth_locked) |-> en_cnt >= LOCK_MIN)
    else $error("lock reported too early");
  c_commit: cover property ($changed(synth_denom));
  c_lock: cover property ($rose(synth_locked));
  c_dmic: cover property (dmic_select == 2'h2);
endmodule : synth_regs_checker

bind synth_record_regs synth_regs_checker chk_u (.*);
`default_nettype wire

// file: verif/tb_top.sv
// Purpose: Self-checking bench for the synthesizer and record registers
// Assumes: Inputs move on the falling edge of a 20 MHz clock
// Notes:   Lock settle count is the full default, about 2000 cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import synth_regs_pkg::*;
();
  logic              sys_clk = 1'b0, rst_n = 1'b0, mclk_active = 1'b0;
  logic              reg_wr, reg_rd, burst_end, synth_frac_mode, synth_enable;
  logic              synth_locked, synth_cfg_valid, analog_front_pd, beep_pass;
  logic              digital_mic_input_one, digital_mic_input_two;
  logic [15:0]       reg_addr, synth_denom, synth_numer;
  logic [7:0]        reg_wdata, reg_rdata, d;
  logic [3:0]        synth_int_mult;
  logic [2:0]        beep_gain_code;
  logic [1:0]        synth_in_div, dmic_select, mixer_boost;
  logic signed [7:0] beep_gain_value;
  bias_mode_t        adc_bias, front_bias;
  int                fail_count = 0, n_tests = 0, cycles = 0;
  typedef struct packed {logic [15:0] a; logic [7:0] w; logic [7:0] e;} row_t;
  row_t rows [8] = '{'{16'h4008, 8'hff, 8'h3f}, '{16'h4008, 8'h1c, 8'h1c},
    '{16'h4008, 8'h25, 8'h25}, '{16'h4009, 8'hff, 8'h7e},
    '{16'h4009, 8'h2a, 8'h2a}, '{16'h4009, 8'h54, 8'h54},
    '{16'h4009, 8'h00, 8'h00}, '{16'h4010, 8'h55, 8'h00}};
  logic signed [7:0] gain_db [8] = '{8'sd0, 8'sd6, 8'sd10, 8'sd14, -8'sd23,
    8'sd20, 8'sd26, 8'sd32};

  synth_record_regs dut_u (.*);
  host_model host_u (.*);

  always #25 sys_clk = ~sys_clk;

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 8000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    repeat (20) @(negedge sys_clk);
    chk({synth_denom, synth_numer}, 48'h0753_0287);
    chk({synth_int_mult, synth_in_div, synth_frac_mode, synth_enable,
      synth_locked}, 48'h064);
    rst_n = 1'b1;
    mclk_active = 1'b1;
    host_u.rd(ADDR_MIC_BEEP, d);
    chk(d, 8'h00);
    // Plain register cases, reserved bits and an unmapped place
    for (int i = 0; i < 8; i++) begin
      host_u.wr(rows[i].a, rows[i].w);
      host_u.rd(rows[i].a, d);
      chk(d, rows[i].e);
      if (rows[i].a == ADDR_MIC_BEEP) begin
        chk(analog_front_pd, rows[i].e[5:4] != 2'h0);
        chk({digital_mic_input_one, digital_mic_input_two},
          {rows[i].e[5:4] == 2'h1, rows[i].e[5:4] == 2'h2});
      end
    end
    // Each beep gain code gives its dB value; the write to 4010 reaches no register
    host_u.wr(16'h4010, 8'h10);
    for (int i = 0; i < 8; i++) begin
      host_u.wr(ADDR_MIC_BEEP, 8'(i));
      @(negedge sys_clk);
      chk(48'(beep_gain_value), 48'(gain_db[i]));
    end
    host_u.burst(48'h007d_000c_2101, 6);
    chk({synth_denom, synth_numer, synth_int_mult, synth_in_div,
      synth_frac_mode, synth_enable}, {16'd125, 16'd12, 8'h43});
    host_u.rd(16'h4007, d);
    chk(d, 8'h01);
    repeat (1900) @(negedge sys_clk);
    chk(synth_locked, 1'b0);
    for (int i = 0; i < 300 && synth_locked !== 1'b1; i++) @(negedge sys_clk);
    host_u.rd(16'h4007, d);
    chk(d, 8'h03);
    // Short burst, then an out-of-range multiplier: both discarded
    host_u.burst(48'h0271_01dd_1901, 4);
    host_u.burst(48'h0271_01dd_4901, 6);
    chk(synth_denom, 16'd125);
    host_u.burst(48'h0271_01dd_1901, 6);
    mclk_active = 1'b0;
    repeat (5) @(negedge sys_clk);
    chk({synth_denom, synth_numer, synth_int_mult},
      {16'd625, 16'd477, 4'd3});
    chk(synth_locked, 1'b1);
    // Integer-N word with zero denominator, synthesizer off
    host_u.burst(48'h0000_0000_1600, 6);
    @(negedge sys_clk);
    chk({synth_in_div, synth_frac_mode, synth_cfg_valid, synth_locked},
      5'b11010);
    // Fractional word with a zero denominator is not usable
    host_u.burst(48'h0000_0000_1101, 6);
    chk(synth_cfg_valid, 1'b0);
    // Mid-run reset puts every field back to its default
    host_u.wr(ADDR_MIC_BEEP, 8'h3b);
    rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk({synth_denom, synth_numer}, 48'h0753_0287);
    chk({dmic_select, beep_pass, beep_gain_code, synth_enable,
      synth_locked}, 48'h0);
    rst_n = 1'b1;
    host_u.rd(ADDR_MIC_BEEP, d);
    chk(d, 8'h00);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
